// ### tsq_pkg.sv
`default_nettype none
package tsq_pkg;
  // ----------------------------------------------------------------
  // Clock and broadcast timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int BCAST_SLOW_MHZ = 10;
  localparam int BCAST_FAST_MHZ = 20;
  localparam int BCAST_SLOW_CYC = (CLK_MHZ + BCAST_SLOW_MHZ - 1) / BCAST_SLOW_MHZ;
  localparam int BCAST_FAST_CYC = (CLK_MHZ + BCAST_FAST_MHZ - 1) / BCAST_FAST_MHZ;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_W      = 12;
  localparam int BUS_W       = 16;
  localparam int GROUP_WORDS = 3;
  localparam logic [3:0] ID_EVENT   = 4'h1;
  localparam logic [3:0] ID_MONITOR = 4'h8;

  // ----------------------------------------------------------------
  // Broadcast queue
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW    = 3;
  localparam int FIFO_W     = 18;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_BC_OFFSET = 8'h04;
  localparam logic [7:0] REG_ORBIT_DIV = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0C;
  localparam logic [7:0] REG_SUPP_CNT  = 8'h10;
  localparam logic [7:0] REG_SAVED_BC  = 8'h14;
  localparam logic [7:0] REG_ORBIT_CNT = 8'h18;
  localparam logic [7:0] REG_DROP_CNT  = 8'h1C;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FAST_BIT = 2;
  localparam int CTRL_MON_BIT  = 3;
  localparam logic [1:0]  CTRL_MODE_RST = 2'h3;
  localparam logic [11:0] BC_OFFSET_RST = 12'h000;
  localparam logic [15:0] ORBIT_DIV_RST = 16'h0000;

  typedef enum logic [1:0] {
    TSQ_KIND_BC   = 2'b00,
    TSQ_KIND_EVLO = 2'b01,
    TSQ_KIND_EVHI = 2'b10
  } tsq_kind_t;

  typedef enum logic [1:0] {
    TSQ_ST_IDLE = 2'b00,
    TSQ_ST_RX   = 2'b01,
    TSQ_ST_MON  = 2'b10
  } tsq_state_t;
endpackage
`default_nettype wire

// ### tsq_bcast_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tsq_bcast_fifo
  import tsq_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                reset_n_i,
  // Control
  input  wire logic                flush_i,
  // Write side
  input  wire logic                wr_en_i,
  input  wire logic [FIFO_W-1:0]   wr_data_i,
  // Read side
  input  wire logic                rd_en_i,
  output logic      [FIFO_W-1:0]   rd_data_o,
  // Status
  output logic                     empty_o,
  output logic                     full_o,
  output logic      [FIFO_AW:0]    free_o
);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][FIFO_W-1:0] mem;
    logic [FIFO_AW-1:0]                wp;
    logic [FIFO_AW-1:0]                rp;
    logic [FIFO_AW:0]                  cnt;
  } tsq_fifo_state_t;

  tsq_fifo_state_t r;
  tsq_fifo_state_t n;
  logic            do_wr;
  logic            do_rd;

  always_comb begin
    n     = r;
    do_wr = wr_en_i && !full_o;
    do_rd = rd_en_i && !empty_o;
    if (do_wr) begin
      n.mem[r.wp] = wr_data_i;
      n.wp        = r.wp + 1'b1;
    end
    if (do_rd) begin
      n.rp = r.rp + 1'b1;
    end
    n.cnt = r.cnt + {{FIFO_AW{1'b0}}, do_wr} - {{FIFO_AW{1'b0}}, do_rd};
    if (flush_i) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rd_data_o = r.mem[r.rp];
  assign empty_o   = (r.cnt == '0);
  assign full_o    = (r.cnt == (FIFO_AW+1)'(FIFO_DEPTH));
  assign free_o    = (FIFO_AW+1)'(FIFO_DEPTH) - r.cnt;
endmodule
`default_nettype wire

// ### tsq_sequencer.sv
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Forward bunch count reset to all boards.
// - Capture bunch counter at each orbit end.
// - Reset every orbit without losing crossings.
// - Subtract offset, merge identifier into event.
// - Queue words, rebroadcast at 10/20 MHz.
// - Monitoring emulates an accept for readout.
// - Allow three monitor requests between accepts.
// - Run start clears, bunch reset advances orbits.
// - Every n orbits assert save-and-reset.
// - Next orbit issues a monitor request.
// - Flow stop blocks accepts, pending readout completes.
// - Flow stop suppresses triggers to timing.
// - Fatal acquisition breakdown cancels queued events.
// - Count accepts suppressed by flow stop.
module tsq_sequencer
  import tsq_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               reset_n_i,
  // Timing receiver side
  input  wire logic               bunch_count_reset_i,
  input  wire logic               level_one_accept_pulse_i,
  input  wire logic [WORD_W-1:0]  counter_bus_i,
  input  wire logic               run_start_pulse_i,
  // Acquisition side
  input  wire logic               flow_stop_i,
  input  wire logic               flow_resume_i,
  input  wire logic               daq_fatal_i,
  input  wire logic               local_trigger_i,
  // Register port
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [BUS_W-1:0]   reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [BUS_W-1:0]   reg_rdata_o,
  // Crate broadcast
  output logic                    bunch_count_reset_o,
  output logic                    orbit_save_reset_o,
  output logic      [BUS_W-1:0]   bcast_data_o,
  output logic                    bcast_bc_stb_o,
  output logic                    bcast_evlo_stb_o,
  output logic                    bcast_evhi_stb_o,
  output logic                    trigger_to_timing_o,
  output logic                    readout_cancel_o
);
  typedef struct packed {
    logic [1:0]        ctrl_mode;
    logic              rate_fast;
    logic [11:0]       bc_offset;
    logic [15:0]       orbit_div;
    logic [15:0]       orbit_cnt;
    logic              save_reset;
    logic              bcr_out;
    logic [11:0]       local_bc;
    logic [11:0]       saved_bc;
    logic              flow_stop;
    logic [15:0]       supp_cnt;
    logic [15:0]       drop_cnt;
    logic [1:0]        mon_pend;
    logic [23:0]       mon_seq;
    tsq_state_t        state;
    logic [1:0]        cap_mode;
    logic [1:0]        cap_idx;
    logic [BUS_W-1:0]  bcast_data;
    logic [2:0]        bcast_stb;
    logic              bcast_busy;
    logic [4:0]        slot_cnt;
    logic [BUS_W-1:0]  rdata;
    logic              cancel;
    logic              trig_out;
  } tsq_state_s_t;

  tsq_state_s_t      r;
  tsq_state_s_t      n;
  logic              push;
  logic [FIFO_W-1:0] push_data;
  logic              pop;
  logic              flush;
  logic [FIFO_W-1:0] fifo_rd_data;
  logic              fifo_empty;
  logic              fifo_full;
  logic [FIFO_AW:0]  fifo_free;
  logic [4:0]        period;
  logic [4:0]        half;
  logic              mon_add_sw;
  logic              mon_add_orbit;
  tsq_kind_t         kind;

  // ----------------------------------------------------------------
  // Word selection and forming
  // ----------------------------------------------------------------
  function automatic tsq_kind_t word_kind(input logic [1:0] mode, input logic [1:0] idx);
    tsq_kind_t k;
    k = TSQ_KIND_EVLO;
    case (mode)
      2'h0: k = TSQ_KIND_EVLO;
      2'h1: k = TSQ_KIND_BC;
      2'h2: k = (idx == 2'h0) ? TSQ_KIND_EVLO : TSQ_KIND_EVHI;
      2'h3: k = (idx == 2'h0) ? TSQ_KIND_BC : ((idx == 2'h1) ? TSQ_KIND_EVLO : TSQ_KIND_EVHI);
      default: k = TSQ_KIND_EVLO;
    endcase
    return k;
  endfunction

  function automatic logic group_last(input logic [1:0] mode, input logic [1:0] idx);
    logic last;
    last = 1'b1;
    case (mode)
      2'h0, 2'h1: last = (idx == 2'h0);
      2'h2: last = (idx == 2'h1);
      2'h3: last = (idx == 2'h2);
      default: last = 1'b1;
    endcase
    return last;
  endfunction

  function automatic logic [FIFO_W-1:0] form_word(input tsq_kind_t k, input logic [11:0] raw,
                                                  input logic [11:0] off, input logic is_mon);
    logic [FIFO_W-1:0] w;
    w = '0;
    case (k)
      TSQ_KIND_BC:   w = {k, 4'h0, raw - off};
      TSQ_KIND_EVLO: w = {k, (is_mon ? ID_MONITOR : ID_EVENT), raw};
      TSQ_KIND_EVHI: w = {k, 4'h0, raw};
      default:       w = '0;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n             = r;
    push          = 1'b0;
    push_data     = '0;
    pop           = 1'b0;
    flush         = 1'b0;
    mon_add_sw    = 1'b0;
    mon_add_orbit = 1'b0;
    kind          = TSQ_KIND_BC;
    period        = r.rate_fast ? 5'(BCAST_FAST_CYC) : 5'(BCAST_SLOW_CYC);
    half          = {1'b0, period[4:1]};

    // Bunch reset fan-out and orbit-end capture
    n.bcr_out = bunch_count_reset_i;
    if (bunch_count_reset_i) begin
      n.local_bc = '0;
      n.saved_bc = r.local_bc;
    end else begin
      n.local_bc = r.local_bc + 12'h001;
    end

    // Orbit divider
    if (run_start_pulse_i) begin
      n.orbit_cnt  = '0;
      n.save_reset = 1'b0;
    end else if (bunch_count_reset_i) begin
      if (r.save_reset) begin
        n.save_reset  = 1'b0;
        mon_add_orbit = 1'b1;
      end else if (r.orbit_div != '0 && r.orbit_cnt == r.orbit_div - 16'h0001) begin
        n.orbit_cnt  = '0;
        n.save_reset = 1'b1;
      end else begin
        n.orbit_cnt = r.orbit_cnt + 16'h0001;
      end
    end

    // Flow control
    if (flow_stop_i) begin
      n.flow_stop = 1'b1;
    end else if (flow_resume_i) begin
      n.flow_stop = 1'b0;
    end
    n.trig_out = local_trigger_i && !r.flow_stop;

    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        REG_CTRL: begin
          n.ctrl_mode = reg_wdata_i[CTRL_MODE_LSB +: 2];
          n.rate_fast = reg_wdata_i[CTRL_FAST_BIT];
          mon_add_sw  = reg_wdata_i[CTRL_MON_BIT];
        end
        REG_BC_OFFSET: n.bc_offset = reg_wdata_i[11:0];
        REG_ORBIT_DIV: n.orbit_div = reg_wdata_i;
        default: n.rdata = n.rdata;
      endcase
    end

    // Capture of receiver and monitor groups
    case (r.state)
      TSQ_ST_RX: begin
        kind      = word_kind(r.cap_mode, r.cap_idx);
        push      = 1'b1;
        push_data = form_word(kind, counter_bus_i, r.bc_offset, 1'b0);
        n.cap_idx = r.cap_idx + 2'h1;
        if (group_last(r.cap_mode, r.cap_idx)) begin
          n.state = TSQ_ST_IDLE;
        end
      end
      TSQ_ST_MON: begin
        kind      = tsq_kind_t'(r.cap_idx);
        push      = 1'b1;
        push_data = form_word(kind, (kind == TSQ_KIND_BC) ? r.local_bc :
                              ((kind == TSQ_KIND_EVLO) ? r.mon_seq[11:0] : r.mon_seq[23:12]),
                              r.bc_offset, 1'b1);
        n.cap_idx = r.cap_idx + 2'h1;
        if (r.cap_idx == 2'h2) begin
          n.state   = TSQ_ST_IDLE;
          n.mon_seq = r.mon_seq + 24'h000001;
        end
      end
      TSQ_ST_IDLE: begin
        if (!level_one_accept_pulse_i && r.mon_pend != 2'h0 && fifo_free >= (FIFO_AW+1)'(GROUP_WORDS)) begin
          n.state    = TSQ_ST_MON;
          n.cap_idx  = 2'h0;
          n.mon_pend = r.mon_pend - 2'h1;
        end
      end
      default: n.state = TSQ_ST_IDLE;
    endcase

    if (level_one_accept_pulse_i) begin
      if (r.flow_stop) begin
        if (r.supp_cnt != 16'hFFFF) begin
          n.supp_cnt = r.supp_cnt + 16'h0001;
        end
      end else if (r.state != TSQ_ST_IDLE || fifo_free < (FIFO_AW+1)'(GROUP_WORDS)) begin
        if (r.drop_cnt != 16'hFFFF) begin
          n.drop_cnt = r.drop_cnt + 16'h0001;
        end
      end else begin
        n.state    = TSQ_ST_RX;
        n.cap_mode = r.ctrl_mode;
        n.cap_idx  = 2'h0;
      end
    end

    // Monitor request accounting, up to three outstanding
    if ((mon_add_sw || mon_add_orbit) && n.mon_pend != 2'h3) begin
      n.mon_pend = n.mon_pend + 2'h1;
    end

    // Reduced-rate rebroadcast
    if (r.bcast_busy && r.slot_cnt != 5'h00) begin
      n.slot_cnt = r.slot_cnt - 5'h01;
      if (n.slot_cnt < half) begin
        n.bcast_stb = 3'h0;
      end
    end else if (!fifo_empty) begin
      pop          = 1'b1;
      n.bcast_busy = 1'b1;
      n.bcast_data = fifo_rd_data[BUS_W-1:0];
      n.bcast_stb  = 3'h1 << fifo_rd_data[FIFO_W-1:BUS_W];
      n.slot_cnt   = period - 5'h01;
    end else begin
      n.bcast_busy = 1'b0;
      n.bcast_stb  = 3'h0;
    end

    // Fatal breakdown
    n.cancel = daq_fatal_i;
    if (daq_fatal_i) begin
      flush        = 1'b1;
      push         = 1'b0;
      pop          = 1'b0;
      n.state      = TSQ_ST_IDLE;
      n.mon_pend   = 2'h0;
      n.bcast_busy = 1'b0;
      n.bcast_stb  = 3'h0;
    end

    // Register reads
    n.rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL:      n.rdata = {12'h000, 1'b0, r.rate_fast, r.ctrl_mode};
        REG_BC_OFFSET: n.rdata = {4'h0, r.bc_offset};
        REG_ORBIT_DIV: n.rdata = r.orbit_div;
        REG_STATUS:    n.rdata = {8'h00, r.state, r.mon_pend, fifo_full, fifo_empty, r.save_reset, r.flow_stop};
        REG_SUPP_CNT:  n.rdata = r.supp_cnt;
        REG_SAVED_BC:  n.rdata = {4'h0, r.saved_bc};
        REG_ORBIT_CNT: n.rdata = r.orbit_cnt;
        REG_DROP_CNT:  n.rdata = r.drop_cnt;
        default:       n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r           <= '0;
      r.ctrl_mode <= CTRL_MODE_RST;
      r.bc_offset <= BC_OFFSET_RST;
      r.orbit_div <= ORBIT_DIV_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Broadcast queue
  // ----------------------------------------------------------------
  tsq_bcast_fifo u_fifo (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .flush_i    (flush),
    .wr_en_i    (push),
    .wr_data_i  (push_data),
    .rd_en_i    (pop),
    .rd_data_o  (fifo_rd_data),
    .empty_o    (fifo_empty),
    .full_o     (fifo_full),
    .free_o     (fifo_free)
  );

  assign reg_rdata_o         = r.rdata;
  assign bunch_count_reset_o = r.bcr_out;
  assign orbit_save_reset_o  = r.save_reset;
  assign bcast_data_o        = r.bcast_data;
  assign bcast_bc_stb_o      = r.bcast_stb[0];
  assign bcast_evlo_stb_o    = r.bcast_stb[1];
  assign bcast_evhi_stb_o    = r.bcast_stb[2];
  assign trigger_to_timing_o = r.trig_out;
  assign readout_cancel_o    = r.cancel;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_orbit_restart;
    r.local_bc == 12'h000 ##1 r.local_bc == 12'h001;
  endsequence

  property p_bcr_fwd;
    bunch_count_reset_i |=> bunch_count_reset_o ##1 !bunch_count_reset_o || $past(bunch_count_reset_i);
  endproperty
  a_bcr_fwd: assert property (p_bcr_fwd) else $error("bunch reset not forwarded");

  property p_orbit_capture;
    bunch_count_reset_i |=> r.saved_bc == $past(r.local_bc);
  endproperty
  a_orbit_capture: assert property (p_orbit_capture) else $error("orbit end count not saved");

  property p_no_lost_bx;
    bunch_count_reset_i ##1 !bunch_count_reset_i |-> s_orbit_restart;
  endproperty
  a_no_lost_bx: assert property (p_no_lost_bx) else $error("crossing count broken at reset");

  property p_event_id;
    push && r.state == TSQ_ST_RX && push_data[FIFO_W-1:BUS_W] == 2'b01 |-> push_data[15:12] == ID_EVENT;
  endproperty
  a_event_id: assert property (p_event_id) else $error("event identifier missing");

  property p_bcast_hold;
    pop && !r.rate_fast |=> ##1 $stable(bcast_data_o) [*8];
  endproperty
  a_bcast_hold: assert property (p_bcast_hold) else $error("broadcast word not held");

  property p_run_clear;
    run_start_pulse_i |=> r.orbit_cnt == 16'h0000 && !orbit_save_reset_o;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run start did not clear orbits");

  property p_save_then_mon;
    bunch_count_reset_i && r.save_reset && !run_start_pulse_i && !daq_fatal_i |=>
      !orbit_save_reset_o && r.mon_pend != 2'h0;
  endproperty
  a_save_then_mon: assert property (p_save_then_mon) else $error("no monitor after save");

  property p_supp_count;
    level_one_accept_pulse_i && r.flow_stop && r.supp_cnt != 16'hFFFF |=>
      r.supp_cnt == $past(r.supp_cnt) + 16'h0001;
  endproperty
  a_supp_count: assert property (p_supp_count) else $error("suppressed accept not counted");

  property p_flow_trig;
    r.flow_stop |=> !trigger_to_timing_o;
  endproperty
  a_flow_trig: assert property (p_flow_trig) else $error("trigger passed during flow stop");

  property p_fatal;
    daq_fatal_i |=> readout_cancel_o && fifo_empty && r.state == TSQ_ST_IDLE;
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal did not cancel readout");
endmodule
`default_nettype wire

// ### tsq_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsq_rx_model
  import tsq_pkg::*;
#(
  parameter int ORBIT_LEN = 100
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_n_i,
  // Bench request
  input  wire logic              fire_i,
  input  wire logic [1:0]        mode_i,
  input  wire logic [23:0]       ev_i,
  // Receiver pins
  output logic                   bunch_count_reset_o,
  output logic                   level_one_accept_pulse_o,
  output logic      [WORD_W-1:0] counter_bus_o,
  output logic      [WORD_W-1:0] acc_bc_o
);
  // ----------------------------------------------------------------
  // Running count and word sequence
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] bc_r;
  logic [WORD_W-1:0] seq_q[$];
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bc_r <= '0;
      bunch_count_reset_o <= 1'b0;
      level_one_accept_pulse_o <= 1'b0;
      counter_bus_o <= '0;
      acc_bc_o <= '0;
      seq_q.delete();
    end else begin
      bc_r <= (bc_r == WORD_W'(ORBIT_LEN - 1)) ? '0 : bc_r + 1'b1;
      bunch_count_reset_o <= (bc_r == WORD_W'(ORBIT_LEN - 2));
      level_one_accept_pulse_o <= fire_i;
      if (fire_i) begin
        acc_bc_o <= bc_r;
        counter_bus_o <= bc_r;
        // Words follow the accept in the order the mode selects
        if (mode_i[0]) seq_q.push_back(bc_r);
        if (mode_i != 2'b01) seq_q.push_back(ev_i[11:0]);
        if (mode_i[1]) seq_q.push_back(ev_i[23:12]);
      end else if (seq_q.size() != 0) begin
        counter_bus_o <= seq_q.pop_front();
      end else begin
        counter_bus_o <= bc_r;
      end
    end
  end
endmodule
`default_nettype wire

// ### tsq_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tsq_sequencer_tb
  import tsq_pkg::*;
();
  typedef struct {logic [2:0] kind; logic [15:0] data; logic [15:0] mask; int gap;} tsq_exp_t;
  logic core_clk_i, reset_n_i, fire_r, fast_r, rx_bc_reset, rx_acc, run_start, flow_stop, flow_resume;
  logic daq_fatal, local_trig, reg_wr, reg_rd, bc_reset_out, save_rst, trig_out, cancel, rx_bc_reset_d;
  logic [1:0] mode_r;
  logic [2:0] stb, stb_prev;
  logic [7:0] reg_addr;
  logic [11:0] off_r, rx_bus, acc_bc;
  logic [15:0] reg_wdata, reg_rdata, bcast_data;
  logic [23:0] ev_r;
  logic [7:0] ra[5] = '{REG_CTRL, REG_BC_OFFSET, REG_ORBIT_DIV, REG_STATUS, 8'h20};
  logic [15:0] rv[5] = '{{14'h0000, CTRL_MODE_RST}, {4'h0, BC_OFFSET_RST}, ORBIT_DIV_RST, 16'h0004, 16'h0000};
  tsq_exp_t exp_q[$];
  int n_errors, cmp_count, since, cycles, n_supp;

  tsq_sequencer DUT (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .bunch_count_reset_i(rx_bc_reset),
    .level_one_accept_pulse_i(rx_acc), .counter_bus_i(rx_bus), .run_start_pulse_i(run_start),
    .flow_stop_i(flow_stop), .flow_resume_i(flow_resume), .daq_fatal_i(daq_fatal),
    .local_trigger_i(local_trig), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .bunch_count_reset_o(bc_reset_out),
    .orbit_save_reset_o(save_rst), .bcast_data_o(bcast_data), .bcast_bc_stb_o(stb[0]),
    .bcast_evlo_stb_o(stb[1]), .bcast_evhi_stb_o(stb[2]), .trigger_to_timing_o(trig_out),
    .readout_cancel_o(cancel));
  tsq_rx_model #(.ORBIT_LEN(100)) rx (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .fire_i(fire_r), .mode_i(mode_r), .ev_i(ev_r),
    .bunch_count_reset_o(rx_bc_reset), .level_one_accept_pulse_o(rx_acc), .counter_bus_o(rx_bus),
    .acc_bc_o(acc_bc));

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // ----------------------------------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------------------------------
  task automatic report(input string msg);
    n_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] expv, input string what);
    cmp_count++;
    if (seen !== expv) report($sformatf("%s got %h expected %h", what, seen, expv));
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic set_mode(input logic [1:0] m, input logic f, input logic mon);
    reg_write(REG_CTRL, {12'h000, mon, f, m});
    mode_r <= m;
    fast_r <= f;
  endtask
  // Expected broadcast words of one group, in queue order
  task automatic push_grp(input logic [1:0] m, input logic [11:0] bc, input logic [23:0] ev, input logic mon);
    int g;
    int sl;
    logic [15:0] mk;
    g = 0;
    sl = fast_r ? BCAST_FAST_CYC : BCAST_SLOW_CYC;
    mk = mon ? 16'hF000 : 16'hFFFF;
    if (m[0]) begin
      exp_q.push_back('{3'b001, {4'h0, bc}, mk, g});
      g = sl;
    end
    if (m != 2'b01) begin
      exp_q.push_back('{3'b010, {(mon ? ID_MONITOR : ID_EVENT), ev[11:0]}, mk, g});
      g = sl;
    end
    if (m[1]) exp_q.push_back('{3'b100, {4'h0, ev[23:12]}, mk, g});
  endtask
  task automatic fire(input logic taken);
    logic [23:0] ev;
    ev = 24'($urandom);
    @(posedge core_clk_i);
    fire_r <= 1'b1;
    ev_r <= ev;
    @(posedge core_clk_i);
    fire_r <= 1'b0;
    #1;
    if (taken) push_grp(mode_r, acc_bc - off_r, ev, 1'b0);
    else n_supp++;
    repeat (3) @(posedge core_clk_i);
  endtask
  task automatic drain();
    for (int i = 0; i < 1000 && exp_q.size() != 0; i++) @(posedge core_clk_i);
    if (exp_q.size() != 0) report("broadcast words missing");
    exp_q.delete();
    repeat (30) @(posedge core_clk_i);
  endtask
  // ----------------------------------------------------------------
  // Broadcast and orbit reset monitor
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    tsq_exp_t e;
    #1;
    cycles++;
    since++;
    if (cycles == 8000) begin
      report("time limit reached");
      summarize();
    end
    if (rx_bc_reset_d || bc_reset_out) check(16'(bc_reset_out), 16'(rx_bc_reset_d), "bunch reset");
    rx_bc_reset_d = rx_bc_reset;
    if ((stb & ~stb_prev) != 3'b000) begin
      if (exp_q.size() == 0) begin
        report("broadcast word not due");
      end else begin
        e = exp_q.pop_front();
        check(16'(stb), 16'(e.kind), "strobe");
        check(bcast_data & e.mask, e.data & e.mask, "word");
        if (e.gap != 0) check(16'(since), 16'(e.gap), "slot length");
      end
      since = 0;
    end
    stb_prev = stb;
  end

  initial begin
    logic [15:0] v;
    int n;
    int seed;
    reset_n_i = 1'b0;
    {fire_r, run_start, flow_stop, flow_resume, daq_fatal, local_trig, reg_wr, reg_rd} = '0;
    {reg_addr, reg_wdata, ev_r, off_r, stb_prev, rx_bc_reset_d, fast_r} = '0;
    mode_r = CTRL_MODE_RST;
    seed = int'($urandom(32'h2354));
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    reg_write(REG_STATUS, 16'hFFFF);
    for (int i = 0; i < 5; i++) begin
      reg_read(ra[i], v);
      check(v, rv[i], "register value after reset");
    end
    $display("register test done");
    for (int m = 0; m < 4; m++) begin
      off_r = 12'($urandom);
      set_mode(2'(m), m[0], 1'b0);
      reg_write(REG_BC_OFFSET, {4'h0, off_r});
      fire(1'b1);
      drain();
      $display("mode %0d test done", m);
    end
    set_mode(2'b11, 1'b0, 1'b0);
    fire(1'b1);
    fire(1'b1);
    drain();
    $display("back to back test done");
    push_grp(2'b11, 12'h000, 24'h000000, 1'b1);
    push_grp(2'b11, 12'h000, 24'h000000, 1'b1);
    set_mode(2'b11, 1'b0, 1'b1);
    set_mode(2'b11, 1'b0, 1'b1);
    drain();
    $display("monitor request test done");
    reg_write(REG_ORBIT_DIV, 16'h0002);
    @(posedge core_clk_i);
    run_start <= 1'b1;
    @(posedge core_clk_i);
    run_start <= 1'b0;
    n = 0;
    for (int i = 0; i < 1000 && save_rst !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
      if (bc_reset_out === 1'b1) n++;
    end
    check(16'(n), 16'h0002, "orbits before save");
    for (int i = 0; i < 1000 && save_rst === 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    check(16'(bc_reset_out), 16'h0001, "save ends at orbit reset");
    push_grp(2'b11, 12'h000, 24'h000000, 1'b1);
    reg_write(REG_ORBIT_DIV, 16'h0000);
    drain();
    $display("orbit monitor test done");
    local_trig <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    check(16'(trig_out), 16'h0001, "trigger passes");
    fire(1'b1);
    @(posedge core_clk_i);
    flow_stop <= 1'b1;
    @(posedge core_clk_i);
    flow_stop <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    check(16'(trig_out), 16'h0000, "trigger held");
    reg_read(REG_STATUS, v);
    check(v & 16'h0001, 16'h0001, "flow stop state");
    repeat (3) fire(1'b0);
    @(posedge core_clk_i);
    flow_resume <= 1'b1;
    @(posedge core_clk_i);
    flow_resume <= 1'b0;
    drain();
    reg_read(REG_SUPP_CNT, v);
    check(v, 16'(n_supp), "suppressed accepts");
    check(16'(trig_out), 16'h0001, "trigger resumes");
    local_trig <= 1'b0;
    $display("flow stop test done");
    fire(1'b1);
    repeat (5) @(posedge core_clk_i);
    daq_fatal <= 1'b1;
    @(posedge core_clk_i);
    daq_fatal <= 1'b0;
    #1;
    check(16'(cancel), 16'h0001, "cancel pulse");
    exp_q.delete();
    @(posedge core_clk_i);
    #1;
    check(16'(cancel), 16'h0000, "cancel one cycle");
    repeat (100) @(posedge core_clk_i);
    reg_read(REG_STATUS, v);
    check(v & 16'h0004, 16'h0004, "queue flushed");
    $display("fatal test done");
    summarize();
  end
endmodule
`default_nettype wire
